// ===== hdl/mdlsl_slice.sv
/*
 * One byte slice of the memory data loop plus its outbound word buffer.
 * Holds the intermediate and auxiliary address registers, the memory
 * data register, two control/status registers with comparators and
 * the boot ROM nibble latches. All strobes come from the controller
 * sequencer on the same clock; only the identity straps are synchronised.
 */
// Function
// - each slice carries one byte of 32
// - move data both ways between buses
// - forward address bits to array address lines
// - return boot PROM words to processor bus
// - match0 high when reg0 equals aux address
// - match1 high when reg1 equals aux address
// - init clears data and both status registers
// - identity straps select byte specific behaviour
// - register input chosen by select and identity
// - output select picks one of four sources
// - latch controls hit ROM latches or registers
// - intermediate strobe holds bus address, else transparent
// - aux strobe holds intermediate value, else transparent
// - data strobe holds bus data, else transparent
// - drive enable puts data onto processor bus
// - internal drive puts data register on internal bus
// - four PROM bits pass through ROM latches
// - address line 1 is ECC disable
// - address line 2 is diagnostic check mode
// - address line 3 is page mode
// - address line 4 enables corrected-data status
// - address line 7 requests uncorrectable error log
// - straps HH,HL,LH,LL give codes 0..3
// - select low takes bus, else code-dependent source
// - codes HH ibus, HL ROM, LH reg0, LL reg1

module mdlsl_fifo
	import mdlsl_pkg::*;
#(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             rst_n_in,
	// fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// drain side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	wire              push;
	wire              pop;
	wire              load_out;

	// --------------------------------------------------------------
	// handshakes
	// --------------------------------------------------------------
	// output stage is a register so the pins come from flops
	assign push     = in_valid_in && in_ready_out;
	assign load_out = (count != '0) && (!out_valid_out || out_ready_in);
	assign pop      = load_out;

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (!push && pop) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr       <= '0;
			rd_ptr       <= '0;
			count        <= '0;
			in_ready_out <= 1'b0;
		end else begin
			count        <= next_count;
			in_ready_out <= (next_count != (AW+1)'(DEPTH));
			if (push) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else if (load_out) begin
			out_valid_out <= 1'b1;
			out_data_out  <= mem[rd_ptr];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end

	AST_FIFO_NO_OVERFLOW: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(count == (AW+1)'(DEPTH)) |-> !in_ready_out)
		else $error("buffer full but still ready");

	AST_FIFO_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(out_valid_out && !out_ready_in) |=> (out_valid_out && $stable(out_data_out)))
		else $error("stalled output word changed");

endmodule

module mdlsl_slice
	import mdlsl_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	// sequencer controls
	input  wire logic        init_n_in,
	input  wire logic [1:0]  ident_in,
	input  wire logic        reg_input_select_n_in,
	input  wire logic [1:0]  bus_output_select_in,
	input  wire logic [1:0]  latch_reg_in,
	input  wire logic        intermediate_addr_strobe_in,
	input  wire logic        aux_addr_strobe_in,
	input  wire logic        data_reg_strobe_in,
	input  wire logic        bus_drive_enable_in,
	input  wire logic        internal_bus_drive_in,
	// processor-memory bus byte lane
	input  wire logic [7:0]  pbus_data_in,
	output logic [7:0]       pbus_data_out,
	output logic             pbus_oe_out,
	output logic             pbus_valid_out,
	input  wire logic        pbus_ready_in,
	output logic             pbus_push_ready_out,
	// internal memory bus byte lane
	input  wire logic [7:0]  ibus_data_in,
	output logic [7:0]       ibus_data_out,
	output logic             ibus_oe_out,
	// boot PROM nibble
	input  wire logic [3:0]  rom_bus_in,
	// address and mode outputs
	output logic [7:0]       array_addr_out,
	output logic             ecc_disable_out,
	output logic             diag_check_out,
	output logic             page_mode_out,
	output logic             corrected_read_data_status_out,
	output logic             read_data_substitute_log_out,
	// comparators
	output logic             reg0_match_out,
	output logic             reg1_match_out
);

	// --------------------------------------------------------------
	// functions
	// --------------------------------------------------------------
	// straps are active high meaning H; HH is byte 0
	function automatic logic [1:0] decode_ident(input logic [1:0] straps);
		decode_ident = ~straps;
	endfunction

	function automatic logic [7:0] addr_mask(input logic [1:0] code);
		case (code)
			BYTE_CODE_0: addr_mask = ADDR_MASK_B0;
			BYTE_CODE_1: addr_mask = ADDR_MASK_B1;
			BYTE_CODE_2: addr_mask = ADDR_MASK_B2;
			default:     addr_mask = ADDR_MASK_B3;
		endcase
	endfunction

	// --------------------------------------------------------------
	// identity strap synchroniser
	// --------------------------------------------------------------
	logic [1:0] ident_meta;
	logic [1:0] ident_sync;
	logic [1:0] byte_code;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ident_meta <= RST_IDENT;
			ident_sync <= RST_IDENT;
			byte_code  <= BYTE_CODE_0;
		end else begin
			ident_meta <= ident_in;
			ident_sync <= ident_meta;
			byte_code  <= decode_ident(ident_sync);
		end
	end

	// --------------------------------------------------------------
	// storage
	// --------------------------------------------------------------
	logic [7:0] intermediate_addr_reg;
	logic [7:0] auxiliary_addr_reg;
	logic [7:0] memory_data_reg;
	logic [7:0] ctrl_status_reg_0;
	logic [7:0] ctrl_status_reg_1;
	logic [3:0] rom_latch_0;
	logic [3:0] rom_latch_1;

	// --------------------------------------------------------------
	// input selection and latch decode
	// --------------------------------------------------------------
	wire        code_uses_ibus;
	wire [7:0]  reg_input;
	wire        rom_assembly;
	wire        reg0_open;
	wire        reg1_open;
	wire        rom0_open;
	wire        rom1_open;
	wire [7:0]  rom_word;
	wire [7:0]  out_source;
	wire [7:0]  next_iar;
	wire [7:0]  next_aux;
	wire [7:0]  next_mdr;
	wire [7:0]  next_reg0;
	wire [7:0]  next_reg1;
	wire        push_valid;
	wire [7:0]  fifo_head;
	wire        fifo_valid;
	wire        fifo_ready;

	assign code_uses_ibus = (byte_code == BYTE_CODE_0) || (byte_code == BYTE_CODE_3);
	assign reg_input      = !reg_input_select_n_in ? pbus_data_in :
	                        (code_uses_ibus ? ibus_data_in : auxiliary_addr_reg);

	// a boot word is assembled while the ROM source is on the bus
	assign rom_assembly = (bus_output_select_in == OUT_SEL_ROM);
	assign rom0_open    = rom_assembly && !latch_reg_in[0];
	assign rom1_open    = rom_assembly && !latch_reg_in[1];
	assign reg0_open    = !rom_assembly && !latch_reg_in[0];
	assign reg1_open    = !rom_assembly && !latch_reg_in[1];
	assign rom_word     = {rom_latch_1, rom_latch_0};

	assign out_source = (bus_output_select_in == OUT_SEL_IBUS) ? ibus_data_in :
	                    (bus_output_select_in == OUT_SEL_ROM)  ? rom_word :
	                    (bus_output_select_in == OUT_SEL_REG0) ? ctrl_status_reg_0 :
	                    ctrl_status_reg_1;

	// each store is transparent while its strobe is low, holds while high
	assign next_iar  = intermediate_addr_strobe_in ? intermediate_addr_reg :
	                   (pbus_data_in & addr_mask(byte_code));
	assign next_aux  = aux_addr_strobe_in ? auxiliary_addr_reg : next_iar;
	assign next_mdr  = !init_n_in ? RST_BYTE :
	                   (data_reg_strobe_in ? memory_data_reg : reg_input);
	assign next_reg0 = !init_n_in ? RST_BYTE :
	                   (reg0_open ? reg_input : ctrl_status_reg_0);
	assign next_reg1 = !init_n_in ? RST_BYTE :
	                   (reg1_open ? reg_input : ctrl_status_reg_1);

	assign push_valid = bus_drive_enable_in;

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			intermediate_addr_reg <= RST_BYTE;
			auxiliary_addr_reg    <= RST_BYTE;
			memory_data_reg       <= RST_BYTE;
			ctrl_status_reg_0     <= RST_BYTE;
			ctrl_status_reg_1     <= RST_BYTE;
		end else begin
			intermediate_addr_reg <= next_iar;
			auxiliary_addr_reg    <= next_aux;
			memory_data_reg       <= next_mdr;
			ctrl_status_reg_0     <= next_reg0;
			ctrl_status_reg_1     <= next_reg1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rom_latch_0 <= RST_NIB;
			rom_latch_1 <= RST_NIB;
		end else begin
			if (rom0_open) begin
				rom_latch_0 <= rom_bus_in;
			end
			if (rom1_open) begin
				rom_latch_1 <= rom_bus_in;
			end
		end
	end

	// --------------------------------------------------------------
	// comparators and address outputs
	// --------------------------------------------------------------
	// compare next values so the flags line up with the registers
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg0_match_out <= 1'b1;
			reg1_match_out <= 1'b1;
		end else begin
			reg0_match_out <= (next_reg0 == next_aux);
			reg1_match_out <= (next_reg1 == next_aux);
		end
	end

	// mode flags use the code that byte_code takes at the same edge, so they never lag it
	wire [1:0] next_byte_code;
	wire       mode_lane;
	assign next_byte_code = decode_ident(ident_sync);
	assign mode_lane      = (next_byte_code == BYTE_CODE_0);

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			array_addr_out                 <= RST_BYTE;
			ecc_disable_out                <= 1'b0;
			diag_check_out                 <= 1'b0;
			page_mode_out                  <= 1'b0;
			corrected_read_data_status_out <= 1'b0;
			read_data_substitute_log_out   <= 1'b0;
		end else begin
			array_addr_out                 <= next_aux;
			ecc_disable_out                <= mode_lane && next_aux[ABIT_ECC_DIS];
			diag_check_out                 <= mode_lane && next_aux[ABIT_DIAG];
			page_mode_out                  <= mode_lane && next_aux[ABIT_PAGE];
			corrected_read_data_status_out <= mode_lane && next_aux[ABIT_CRD_EN];
			read_data_substitute_log_out   <= mode_lane && next_aux[ABIT_RDS_LOG];
		end
	end

	// --------------------------------------------------------------
	// bus drivers
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ibus_data_out <= RST_BYTE;
			ibus_oe_out   <= 1'b0;
		end else begin
			ibus_data_out <= memory_data_reg;
			ibus_oe_out   <= internal_bus_drive_in;
		end
	end

	// outbound words queue so a slow bus stalls the sequencer, not data
	mdlsl_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_out_fifo (
		.ref_clk_in    (ref_clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (push_valid),
		.in_data_in    (out_source),
		.in_ready_out  (fifo_ready),
		.out_valid_out (fifo_valid),
		.out_data_out  (fifo_head),
		.out_ready_in  (pbus_ready_in)
	);

	assign pbus_data_out       = fifo_head;
	assign pbus_valid_out      = fifo_valid;
	assign pbus_oe_out         = fifo_valid;
	assign pbus_push_ready_out = fifo_ready;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	AST_INIT_CLEARS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!init_n_in |=> (memory_data_reg == 8'h00 && ctrl_status_reg_0 == 8'h00
		                && ctrl_status_reg_1 == 8'h00))
		else $error("init did not clear registers");

	AST_MATCH0: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		reg0_match_out == (ctrl_status_reg_0 == auxiliary_addr_reg))
		else $error("reg0 match wrong");

	AST_MATCH1: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		reg1_match_out == (ctrl_status_reg_1 == auxiliary_addr_reg))
		else $error("reg1 match wrong");

	AST_MDR_HOLDS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(data_reg_strobe_in && init_n_in) |=> $stable(memory_data_reg))
		else $error("data register moved while strobed");

	AST_MDR_FROM_BUS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!data_reg_strobe_in && init_n_in && !reg_input_select_n_in)
		|=> memory_data_reg == $past(pbus_data_in))
		else $error("data register not loaded from bus");

	AST_IAR_HOLDS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		intermediate_addr_strobe_in |=> $stable(intermediate_addr_reg))
		else $error("intermediate address moved while strobed");

	AST_AUX_FOLLOWS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!aux_addr_strobe_in && intermediate_addr_strobe_in)
		|=> auxiliary_addr_reg == $past(intermediate_addr_reg))
		else $error("aux address not transparent");

	AST_IBUS_DRIVE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		internal_bus_drive_in |=> (ibus_oe_out && ibus_data_out == $past(memory_data_reg)))
		else $error("internal bus not driven with data register");

	AST_PAGE_MODE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		page_mode_out == (byte_code == BYTE_CODE_0 && auxiliary_addr_reg[ABIT_PAGE]))
		else $error("page mode does not follow address line 3");

	AST_ROM_HOLDS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!rom_assembly |=> $stable(rom_word))
		else $error("boot latch moved outside assembly");

endmodule

// ===== hdl/mdlsl_pkg.sv
/*
 * Constants for one byte slice of the memory data loop: data widths,
 * slice identity codes, bus-output select codes, address masks, mode bit positions,
 * reset values and the depth of the outbound word buffer.
 * Assumes a single 20 MHz clock shared with the controller sequencer.
 */
package mdlsl_pkg;

	// --------------------------------------------------------------
	// widths
	// --------------------------------------------------------------
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned ROM_NIB_W  = 4;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned CLK_HZ     = 20_000_000;

	// --------------------------------------------------------------
	// byte codes decoded from the identity straps
	// --------------------------------------------------------------
	localparam logic [1:0] BYTE_CODE_0 = 2'h0;
	localparam logic [1:0] BYTE_CODE_1 = 2'h1;
	localparam logic [1:0] BYTE_CODE_2 = 2'h2;
	localparam logic [1:0] BYTE_CODE_3 = 2'h3;

	// --------------------------------------------------------------
	// processor-bus output source select
	// --------------------------------------------------------------
	localparam logic [1:0] OUT_SEL_IBUS = 2'h3;
	localparam logic [1:0] OUT_SEL_ROM  = 2'h2;
	localparam logic [1:0] OUT_SEL_REG0 = 2'h1;
	localparam logic [1:0] OUT_SEL_REG1 = 2'h0;

	// --------------------------------------------------------------
	// address masks per byte code (bus bits 23..2 only)
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_MASK_B0 = 8'hfc;
	localparam logic [7:0] ADDR_MASK_B1 = 8'hff;
	localparam logic [7:0] ADDR_MASK_B2 = 8'hff;
	localparam logic [7:0] ADDR_MASK_B3 = 8'h00;

	// --------------------------------------------------------------
	// mode bit positions on the address output of byte 0
	// --------------------------------------------------------------
	localparam int unsigned ABIT_ECC_DIS   = 1;
	localparam int unsigned ABIT_DIAG      = 2;
	localparam int unsigned ABIT_PAGE      = 3;
	localparam int unsigned ABIT_CRD_EN    = 4;
	localparam int unsigned ABIT_RDS_LOG   = 7;

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [3:0] RST_NIB    = 4'h0;
	localparam logic [1:0] RST_IDENT  = 2'h3;

endpackage

// ===== testbench/mdlsl_bus_sink.sv
/*
 * Consumer model for the processor-bus side of the slice's out buffer.
 * Assumes the bench drives stall and pace controls off the falling edge.
 */
module mdlsl_bus_sink (
	// clock and reset
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	// pace control
	input  wire logic stall_in,
	input  wire logic slow_in,
	// handshake
	output logic      ready_out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial ready_out = 1'b0;

	// slow pace takes a word on about half the cycles, like a busy bus
	always @(negedge ref_clk_in) begin
		ready_out <= rst_n_in && !stall_in && (!slow_in || $urandom_range(1));
	end
endmodule

// ===== testbench/tb_top.sv
/*
 * Self-checking bench for one memory data loop slice and its out buffer.
 * Assumes the slice's inputs share the 20 MHz clock, apart from the straps.
 */
module tb_top
	import mdlsl_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk, rst_n, init_n, sel_n, iar_stb, aux_stb, mdr_stb;
	logic       drv_en, ibus_drv, pbus_oe, pbus_valid, pbus_ready, push_rdy;
	logic       ibus_oe, ecc, diag, page, corrected_read_data, read_data_substitute, m0, m1, stall, slow;
	logic [1:0] ident, osel, latch;
	logic [3:0] rom, n0, n1;
	logic [7:0] pbus_in, pbus_out, ibus_in, ibus_out, addr, a, b, c, d, v;
	logic [7:0] exp_q[$];
	int         err_total, checks, n, k;

	mdlsl_slice dut (.ref_clk_in(clk), .rst_n_in(rst_n), .init_n_in(init_n),
		.ident_in(ident), .reg_input_select_n_in(sel_n), .bus_output_select_in(osel),
		.latch_reg_in(latch), .intermediate_addr_strobe_in(iar_stb),
		.aux_addr_strobe_in(aux_stb), .data_reg_strobe_in(mdr_stb),
		.bus_drive_enable_in(drv_en), .internal_bus_drive_in(ibus_drv),
		.pbus_data_in(pbus_in), .pbus_data_out(pbus_out), .pbus_oe_out(pbus_oe),
		.pbus_valid_out(pbus_valid), .pbus_ready_in(pbus_ready),
		.pbus_push_ready_out(push_rdy), .ibus_data_in(ibus_in),
		.ibus_data_out(ibus_out), .ibus_oe_out(ibus_oe), .rom_bus_in(rom),
		.array_addr_out(addr), .ecc_disable_out(ecc), .diag_check_out(diag),
		.page_mode_out(page), .corrected_read_data_status_out(corrected_read_data),
		.read_data_substitute_log_out(read_data_substitute), .reg0_match_out(m0), .reg1_match_out(m1));

	mdlsl_bus_sink u_sink (.ref_clk_in(clk), .rst_n_in(rst_n), .stall_in(stall),
		.slow_in(slow), .ready_out(pbus_ready));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic step(int cnt = 1);
		repeat (cnt) @(negedge clk);
	endtask

	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
			err_total++;
		end
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// leaves the enable high; the caller lowers it after a burst
	task automatic push(logic [1:0] sel, logic [7:0] exp);
		int i;
		for (i = 0; i < 100 && push_rdy !== 1'b1; i++) step();
		if (push_rdy !== 1'b1) begin
			err_total++;
			results();
		end
		osel = sel;
		drv_en = 1'b1;
		exp_q.push_back(exp);
		step();
	endtask

	task automatic drain();
		int i;
		for (i = 0; i < 500 && exp_q.size() != 0; i++) step();
		if (exp_q.size() != 0) begin
			err_total++;
			results();
		end
	endtask

	function automatic logic [7:0] mask(int code);
		case (code)
			0: return ADDR_MASK_B0;
			1: return ADDR_MASK_B1;
			2: return ADDR_MASK_B2;
			default: return ADDR_MASK_B3;
		endcase
	endfunction

	function automatic logic [4:0] modes(logic [7:0] x);
		return {x[1], x[2], x[3], x[4], x[7]};
	endfunction

	// --------------------------------------------------------------
	// out buffer scoreboard: oldest note against each word taken
	// --------------------------------------------------------------
	always @(posedge clk) begin
		if (rst_n && pbus_valid === 1'b1 && pbus_ready === 1'b1) begin
			chk("pending", 8'h01, {7'h0, exp_q.size() > 0});
			if (exp_q.size() > 0) chk("pbus word", exp_q.pop_front(), pbus_out);
			chk("pbus oe", 8'h01, {7'h0, pbus_oe});
		end
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		{rst_n, sel_n, osel, drv_en, ibus_drv, stall, slow} = '0;
		{init_n, iar_stb, aux_stb, mdr_stb} = 4'hf;
		latch = 2'h3;
		ident = 2'h2;
		{pbus_in, ibus_in, rom} = '0;
		void'($urandom(32'h17c3b72b));
		step(5);
		chk("match0 in reset", 8'h01, {7'h0, m0});
		chk("match1 in reset", 8'h01, {7'h0, m1});
		chk("valid in reset", 8'h00, {7'h0, pbus_valid});
		step();
		rst_n = 1'b1;
		step(4);
		$display("test reset done");

		{iar_stb, aux_stb} = 2'h0;
		for (n = 0; n < 4; n++) begin
			ident = 2'h3 - n[1:0];
			step(4);
			d = $urandom;
			for (k = 0; k < 2; k++) begin
				v = k ? ~d : d;
				pbus_in = v;
				step();
				chk("array addr", v & mask(n), addr);
				chk("modes", {3'h0, n == 0 ? modes(v & mask(0)) : 5'h0},
					{3'h0, ecc, diag, page, corrected_read_data, read_data_substitute});
			end
		end
		ident = 2'h2;
		step(4);
		a = $urandom;
		pbus_in = a;
		step();
		iar_stb = 1'b1;
		pbus_in = ~a;
		step();
		chk("addr held", a, addr);
		iar_stb = 1'b0;
		aux_stb = 1'b1;
		step();
		chk("aux held", a, addr);
		aux_stb = 1'b0;
		step();
		chk("aux follows", ~a, addr);
		a = ~a;
		{iar_stb, aux_stb} = 2'h3;
		$display("test address done");

		// code 1: bus feeds reg0, then the aux address feeds reg1
		do b = $urandom; while (b == a);
		osel = 2'h1;
		latch = 2'h2;
		pbus_in = b;
		step();
		sel_n = 1'b1;
		latch = 2'h1;
		pbus_in = $urandom;
		step();
		latch = 2'h3;
		chk("match0", 8'h00, {7'h0, m0});
		chk("match1", 8'h01, {7'h0, m1});
		push(2'h1, b);
		push(2'h0, a);
		drv_en = 1'b0;
		{iar_stb, aux_stb} = 2'h0;
		pbus_in = b;
		step();
		{iar_stb, aux_stb} = 2'h3;
		chk("match0 aux moved", 8'h01, {7'h0, m0});
		chk("match1 aux moved", 8'h00, {7'h0, m1});
		drain();
		$display("test registers done");

		// code 0 with select high takes the internal bus
		ident = 2'h3;
		step(4);
		c = $urandom;
		ibus_in = c;
		mdr_stb = 1'b0;
		ibus_drv = 1'b1;
		step();
		mdr_stb = 1'b1;
		ibus_in = ~c;
		step();
		chk("ibus data", c, ibus_out);
		chk("ibus oe", 8'h01, {7'h0, ibus_oe});
		d = $urandom;
		sel_n = 1'b0;
		pbus_in = d;
		mdr_stb = 1'b0;
		step();
		mdr_stb = 1'b1;
		pbus_in = ~d;
		step();
		chk("data reg", d, ibus_out);
		init_n = 1'b0;
		step();
		init_n = 1'b1;
		step();
		chk("data reg init", 8'h00, ibus_out);
		chk("match0 init", {7'h0, b == 8'h00}, {7'h0, m0});
		ibus_drv = 1'b0;
		step(2);
		chk("ibus oe off", 8'h00, {7'h0, ibus_oe});
		$display("test data register done");

		// nibbles assemble while the status registers must hold
		n0 = $urandom;
		n1 = $urandom;
		osel = 2'h2;
		latch = 2'h2;
		rom = n0;
		pbus_in = 8'h5a;
		step();
		latch = 2'h1;
		rom = n1;
		step();
		latch = 2'h3;
		rom = ~n1;
		step();
		push(2'h1, 8'h00);
		push(2'h0, 8'h00);
		push(2'h2, {n1, n0});
		drv_en = 1'b0;
		drain();
		$display("test boot data done");

		stall = 1'b1;
		step();
		osel = 2'h3;
		drv_en = 1'b1;
		n = 0;
		for (k = 0; k < 12; k++) begin
			c = $urandom;
			ibus_in = c;
			if (push_rdy === 1'b1) begin
				exp_q.push_back(c);
				n++;
			end
			step();
		end
		drv_en = 1'b0;
		chk("fill then refuse", 8'h01, {7'h0, n >= FIFO_DEPTH && n < 12});
		chk("push ready full", 8'h00, {7'h0, push_rdy});
		slow = 1'b1;
		stall = 1'b0;
		drain();
		step(3);
		chk("valid drained", 8'h00, {7'h0, pbus_valid});
		$display("test buffer done");
		results();
	end
endmodule
